/* File: rtl/dtc_top.sv */
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_top
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// External count and gate pins
	input wire logic count_input_a_i,
	input wire logic count_input_b_i,
	input wire logic gate_input_a_i,
	input wire logic gate_input_b_i,
	// Interrupt
	output logic irq_o
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	// Software registers
	logic [7:0] ctrl_ff, nxt_ctrl; // Run bits and overflow flags
	logic [7:0] mode_ff; // Mode, counter select and gate bits
	logic [7:0] scale_ff; // Prescale field and system clock selects
	logic [7:0] xcfg_ff; // Gate polarity bits
	logic [7:0] ien_ff; // Interrupt enables
	logic [1:0] istat_ff, nxt_istat; // Sticky interrupt status
	// Read path and interrupt outputs
	logic [7:0] rdata_ff; // Read data, valid one cycle after strobe
	logic irq_ff; // Registered interrupt level
	// Prescaler
	logic [7:0] pre_cnt_ff; // Free running divider count
	// Per pin and per timer vectors
	logic [3:0] pin_raw; // Pins in order count a, count b, gate a, gate b
	logic [3:0] pin_lvl; // Filtered pin levels
	logic [3:0] pin_fall; // One cycle pulse on accepted falling edge
	logic [7:0] t_lo [2]; // Timer low bytes
	logic [7:0] t_hi [2]; // Timer high bytes
	logic [1:0] t_ovf; // Overflow pulses from the timers
	logic [1:0] lo_we; // Low byte write enables
	logic [1:0] hi_we; // High byte write enables
	dtc_tcfg_t t_cfg [2]; // Per timer configuration bundles

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	// Write selects, one named wire per register
	wire wr_a_lo = wr_i && (addr_i == `DTC_ADDR_A_LO);
	wire wr_a_hi = wr_i && (addr_i == `DTC_ADDR_A_HI);
	wire wr_b_lo = wr_i && (addr_i == `DTC_ADDR_B_LO);
	wire wr_b_hi = wr_i && (addr_i == `DTC_ADDR_B_HI);
	wire wr_ctrl = wr_i && (addr_i == `DTC_ADDR_CTRL);
	wire wr_mode = wr_i && (addr_i == `DTC_ADDR_MODE);
	wire wr_scale = wr_i && (addr_i == `DTC_ADDR_SCALE);
	wire wr_xcfg = wr_i && (addr_i == `DTC_ADDR_XCFG);
	wire wr_ien = wr_i && (addr_i == `DTC_ADDR_IEN);
	wire wr_iclr = wr_i && (addr_i == `DTC_ADDR_ICLR);
	// Byte enables gathered per timer
	assign lo_we = {wr_b_lo, wr_a_lo};
	assign hi_we = {wr_b_hi, wr_a_hi};

	// ---------------------------------------------------------------
	// Read selection
	// ---------------------------------------------------------------
	// Unmapped and write-only addresses read as zero
	wire [7:0] rd_mux =
		(addr_i == `DTC_ADDR_A_LO) ? t_lo[0] :
		(addr_i == `DTC_ADDR_A_HI) ? t_hi[0] :
		(addr_i == `DTC_ADDR_B_LO) ? t_lo[1] :
		(addr_i == `DTC_ADDR_B_HI) ? t_hi[1] :
		(addr_i == `DTC_ADDR_CTRL) ? ctrl_ff :
		(addr_i == `DTC_ADDR_MODE) ? mode_ff :
		(addr_i == `DTC_ADDR_SCALE) ? scale_ff :
		(addr_i == `DTC_ADDR_XCFG) ? xcfg_ff :
		(addr_i == `DTC_ADDR_IEN) ? ien_ff :
		(addr_i == `DTC_ADDR_ISTAT) ? {6'h00, istat_ff} :
		8'h00;

	// Read data holds only in the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_ff <= `DTC_RST_BYTE;
		end else begin
			rdata_ff <= rd_i ? rd_mux : 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	// Plain stored registers; unused bits are masked to read zero
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_ff <= `DTC_RST_BYTE;
			scale_ff <= `DTC_RST_BYTE;
			xcfg_ff <= `DTC_RST_BYTE;
			ien_ff <= `DTC_RST_BYTE;
		end else begin
			if (wr_mode) begin
				mode_ff <= wdata_i;
			end
			if (wr_scale) begin
				scale_ff <= wdata_i & `DTC_SCALE_MASK;
			end
			if (wr_xcfg) begin
				xcfg_ff <= wdata_i & `DTC_XCFG_MASK;
			end
			if (wr_ien) begin
				ien_ff <= wdata_i & `DTC_IRQ_MASK;
			end
		end
	end

	// ---------------------------------------------------------------
	// Control register with overflow flags
	// ---------------------------------------------------------------
	// Hardware set of an overflow flag wins over a software write,
	// so an overflow in the clearing cycle is never lost
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl = wdata_i & `DTC_CTRL_MASK;
		end
		if (t_ovf[0]) begin
			nxt_ctrl[`DTC_CTRL_OVF_A] = 1'b1;
		end
		if (t_ovf[1]) begin
			nxt_ctrl[`DTC_CTRL_OVF_B] = 1'b1;
		end
	end

	// Control state register
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_ff <= `DTC_RST_BYTE;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status, clear and output
	// ---------------------------------------------------------------
	// Sticky status; a new event in the clear cycle survives
	always_comb begin
		nxt_istat = istat_ff;
		if (wr_iclr) begin
			nxt_istat = istat_ff & ~wdata_i[1:0];
		end
		nxt_istat = nxt_istat | t_ovf;
	end

	// Interrupt level lags the status by one cycle, a small price
	// for an output that comes straight from a flip-flop
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			istat_ff <= 2'h0;
			irq_ff <= 1'b0;
		end else begin
			istat_ff <= nxt_istat;
			irq_ff <= |(istat_ff & ien_ff[1:0]);
		end
	end

	// ---------------------------------------------------------------
	// Prescaler
	// ---------------------------------------------------------------
	// Divisor chosen by the clock scale field
	wire [1:0] scale_sel = scale_ff[`DTC_SCALE_LSB +: 2];
	wire [7:0] div_val =
		(scale_sel == 2'h0) ? `DTC_DIV_0 :
		(scale_sel == 2'h1) ? `DTC_DIV_1 :
		(scale_sel == 2'h2) ? `DTC_DIV_2 :
		`DTC_DIV_3;
	wire [7:0] div_last = div_val - 8'h01;
	// Compare with >= so a smaller divisor written mid-count recovers
	wire pre_tick = pre_cnt_ff >= div_last;

	// Divider count, shared by both timers
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_cnt_ff <= 8'h00;
		end else begin
			pre_cnt_ff <= pre_tick ? 8'h00 : pre_cnt_ff + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	assign pin_raw = {gate_input_b_i, gate_input_a_i, count_input_b_i, count_input_a_i};

	// Three stages per pin; a change is taken once stages two and
	// three agree, which also filters a single-cycle glitch
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_sync
			logic s1_ff; // Metastability catch, read by s2 only
			logic s2_ff; // Second stage
			logic s3_ff; // Third stage
			logic lvl_ff; // Accepted level
			wire agree = s2_ff == s3_ff;
			// Shift chain and accepted level
			always_ff @(posedge sys_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					lvl_ff <= 1'b0;
				end else begin
					s1_ff <= pin_raw[gp];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (agree) begin
						lvl_ff <= s3_ff;
					end
				end
			end
			assign pin_lvl[gp] = lvl_ff;
			// Falling edge accepted in this cycle
			assign pin_fall[gp] = agree && lvl_ff && !s3_ff;
		end
	endgenerate

	// ---------------------------------------------------------------
	// Timer configuration bundles
	// ---------------------------------------------------------------
	// Each timer takes its own slice of the shared registers
	assign t_cfg[0] = '{
		mode: dtc_mode_t'(mode_ff[`DTC_MODE_A_LSB +: 2]),
		ct: mode_ff[`DTC_MODE_CT_A],
		gate: mode_ff[`DTC_MODE_GATE_A],
		sysclk: scale_ff[`DTC_SCALE_SYS_A],
		run: ctrl_ff[`DTC_CTRL_RUN_A],
		pol: xcfg_ff[`DTC_XCFG_POL_A]
	};
	assign t_cfg[1] = '{
		mode: dtc_mode_t'(mode_ff[`DTC_MODE_B_LSB +: 2]),
		ct: mode_ff[`DTC_MODE_CT_B],
		gate: mode_ff[`DTC_MODE_GATE_B],
		sysclk: scale_ff[`DTC_SCALE_SYS_B],
		run: ctrl_ff[`DTC_CTRL_RUN_B],
		pol: xcfg_ff[`DTC_XCFG_POL_B]
	};

	// ---------------------------------------------------------------
	// Timer instances
	// ---------------------------------------------------------------
	// Identical timers; only their inputs differ
	genvar gt;
	generate
		for (gt = 0; gt < 2; gt++) begin : g_timer
			dtc_timer u_timer (
				.sys_clk_i(sys_clk_i),
				.rstn_i(rstn_i),
				.cfg_i(t_cfg[gt]),
				.pre_tick_i(pre_tick),
				.pin_fall_i(pin_fall[gt]),
				.gate_lvl_i(pin_lvl[gt + 2]),
				.lo_we_i(lo_we[gt]),
				.hi_we_i(hi_we[gt]),
				.wdata_i(wdata_i),
				.lo_o(t_lo[gt]),
				.hi_o(t_hi[gt]),
				.ovf_o(t_ovf[gt])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign rdata_o = rdata_ff;
	assign irq_o = irq_ff;
endmodule : dtc_top

/* File: rtl/dtc_cfg.svh */
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define DTC_ADDR_A_LO 8'h00
`define DTC_ADDR_A_HI 8'h01
`define DTC_ADDR_B_LO 8'h02
`define DTC_ADDR_B_HI 8'h03
`define DTC_ADDR_CTRL 8'h04
`define DTC_ADDR_MODE 8'h05
`define DTC_ADDR_SCALE 8'h06
`define DTC_ADDR_XCFG 8'h07
`define DTC_ADDR_IEN 8'h08
`define DTC_ADDR_ISTAT 8'h09
`define DTC_ADDR_ICLR 8'h0a
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DTC_CTRL_RUN_A 4
`define DTC_CTRL_OVF_A 5
`define DTC_CTRL_RUN_B 6
`define DTC_CTRL_OVF_B 7
`define DTC_CTRL_MASK 8'hf0
`define DTC_MODE_A_LSB 0
`define DTC_MODE_CT_A 2
`define DTC_MODE_GATE_A 3
`define DTC_MODE_B_LSB 4
`define DTC_MODE_CT_B 6
`define DTC_MODE_GATE_B 7
`define DTC_SCALE_LSB 0
`define DTC_SCALE_SYS_A 2
`define DTC_SCALE_SYS_B 3
`define DTC_SCALE_MASK 8'h0f
`define DTC_XCFG_POL_A 3
`define DTC_XCFG_POL_B 7
`define DTC_XCFG_MASK 8'h88
`define DTC_IRQ_MASK 8'h03
// ---------------------------------------------------------------
// Reset values and prescaler divisors
// ---------------------------------------------------------------
`define DTC_RST_BYTE 8'h00
`define DTC_DIV_0 8'h02
`define DTC_DIV_1 8'h04
`define DTC_DIV_2 8'h08
`define DTC_DIV_3 8'h10
`define DTC_LO13_MASK 8'h1f
`endif

/* File: rtl/dtc_pkg.sv */
// ---------------------------------------------------------------
// Shared types of the dual timer
// ---------------------------------------------------------------
package dtc_pkg;
	// Operating mode codes of one timer
	typedef enum logic [1:0] {
		DTC_MODE_13 = 2'h0,
		DTC_MODE_16 = 2'h1,
		DTC_MODE_R8 = 2'h2,
		DTC_MODE_SP = 2'h3
	} dtc_mode_t;
	// Per-timer configuration carried as one bundle
	typedef struct packed {
		dtc_mode_t mode; // Counter width selection
		logic ct; // 1: count pin falling edges
		logic gate; // 1: gate input qualifies counting
		logic sysclk; // 1: count every system clock when ct is 0
		logic run; // Run enable
		logic pol; // Active level of the gate input
	} dtc_tcfg_t;
endpackage : dtc_pkg

/* File: rtl/dtc_timer.sv */
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Configuration and count sources
	input wire dtc_tcfg_t cfg_i,
	input wire logic pre_tick_i,
	input wire logic pin_fall_i,
	input wire logic gate_lvl_i,
	// Byte writes from software
	input wire logic lo_we_i,
	input wire logic hi_we_i,
	input wire logic [7:0] wdata_i,
	// Count bytes and overflow event
	output logic [7:0] lo_o,
	output logic [7:0] hi_o,
	output logic ovf_o
);
	// ---------------------------------------------------------------
	// Count qualification
	// ---------------------------------------------------------------
	logic [7:0] lo_ff, nxt_lo;
	logic [7:0] hi_ff, nxt_hi;
	logic ovf_ff;
	wire gate_ok = !cfg_i.gate || (gate_lvl_i == cfg_i.pol);
	wire src_tick = cfg_i.ct ? pin_fall_i : (cfg_i.sysclk ? 1'b1 : pre_tick_i);
	wire mode_13 = cfg_i.mode == DTC_MODE_13;
	wire mode_16 = cfg_i.mode == DTC_MODE_16;
	// Unsupported modes hold the count rather than guess a behaviour
	wire cnt_en = cfg_i.run && gate_ok && src_tick && (mode_13 || mode_16);
	wire [12:0] c13 = {hi_ff, lo_ff[4:0]};
	wire [12:0] c13_inc = c13 + 13'h0001;
	wire [15:0] c16_inc = {hi_ff, lo_ff} + 16'h0001;
	wire wrap = mode_13 ? (c13 == 13'h1fff) : ({hi_ff, lo_ff} == 16'hffff);
	wire sw_wr = lo_we_i || hi_we_i;
	// A software write beats the increment, so no wrap is seen that cycle
	wire ovf_evt = cnt_en && wrap && !sw_wr;
	// ---------------------------------------------------------------
	// Next count
	// ---------------------------------------------------------------
	always_comb begin
		nxt_lo = lo_ff;
		nxt_hi = hi_ff;
		if (sw_wr) begin
			if (lo_we_i) begin
				nxt_lo = wdata_i;
			end
			if (hi_we_i) begin
				nxt_hi = wdata_i;
			end
		end else if (cnt_en && mode_13) begin
			// Upper three low bits are not part of the count
			nxt_lo = {lo_ff[7:5], c13_inc[4:0]};
			nxt_hi = c13_inc[12:5];
		end else if (cnt_en) begin
			nxt_lo = c16_inc[7:0];
			nxt_hi = c16_inc[15:8];
		end
	end
	// Count registers resume from their value; run never clears them
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lo_ff <= `DTC_RST_BYTE;
			hi_ff <= `DTC_RST_BYTE;
			ovf_ff <= 1'b0;
		end else begin
			lo_ff <= nxt_lo;
			hi_ff <= nxt_hi;
			ovf_ff <= ovf_evt;
		end
	end
	assign lo_o = lo_ff;
	assign hi_o = hi_ff;
	assign ovf_o = ovf_ff;
endmodule : dtc_timer

/* File: testbench/dtc_pin_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Count and gate pins outside the timers
// ---------------------------------------------------------------
module dtc_pin_model (
	// Clock, reset and commands from the bench
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [1:0] fall_i,
	input wire logic [1:0] gate_i,
	// Pins towards the timers
	output logic [1:0] cnt_o,
	output logic [1:0] gate_o
);
	logic [3:0] low_a; // Cycles left low on pin a
	logic [3:0] low_b; // Cycles left low on pin b
	// Hold each fall low for 8 cycles so the synchroniser sees it
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_a <= 4'h0;
			low_b <= 4'h0;
			gate_o <= 2'h0;
		end else begin
			low_a <= fall_i[0] ? 4'h8 : low_a - {3'h0, low_a != 4'h0};
			low_b <= fall_i[1] ? 4'h8 : low_b - {3'h0, low_b != 4'h0};
			gate_o <= gate_i;
		end
	end
	// Pins idle high, so only commanded falls are seen
	assign cnt_o = {low_b == 4'h0, low_a == 4'h0};
endmodule : dtc_pin_model

/* File: testbench/dtc_top_asserts.sv */
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_top_asserts
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Pins and interrupt
	input wire logic count_input_a_i,
	input wire logic count_input_b_i,
	input wire logic gate_input_a_i,
	input wire logic gate_input_b_i,
	input wire logic irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [7:0] mode_sh_ff; // Last mode write
	logic [7:0] xcfg_sh_ff; // Last polarity write
	logic [7:0] ien_sh_ff; // Last enable write
	// ---------------------------------------------------------------
	// Shadows of software-only registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_sh_ff <= 8'h00;
			xcfg_sh_ff <= 8'h00;
			ien_sh_ff <= 8'h00;
		end else if (wr_i) begin
			if (addr_i == `DTC_ADDR_MODE) mode_sh_ff <= wdata_i;
			if (addr_i == `DTC_ADDR_XCFG) xcfg_sh_ff <= wdata_i;
			if (addr_i == `DTC_ADDR_IEN) ien_sh_ff <= wdata_i;
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	sequence s_rd(logic [7:0] a);
		rd_i && addr_i == a;
	endsequence
	property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
	property p_ctrl_low; s_rd(`DTC_ADDR_CTRL) |=> rdata_o[3:0] == 4'h0; endproperty
	property p_iclr; s_rd(`DTC_ADDR_ICLR) |=> rdata_o == 8'h00; endproperty
	property p_istat; s_rd(`DTC_ADDR_ISTAT) |=> rdata_o[7:2] == 6'h00; endproperty
	property p_mode; s_rd(`DTC_ADDR_MODE) |=> rdata_o == mode_sh_ff; endproperty
	property p_xcfg; s_rd(`DTC_ADDR_XCFG) |=> rdata_o == (xcfg_sh_ff & 8'h88); endproperty
	property p_ien; s_rd(`DTC_ADDR_IEN) |=> rdata_o == (ien_sh_ff & 8'h03); endproperty
	// Lag of two cycles allowed before a disabled line must drop
	property p_irq_mask; (ien_sh_ff[1:0] == 2'h0) [*3] |-> !irq_o; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_ctrl_low: assert property (p_ctrl_low) else $error("control low bits set");
	a_iclr: assert property (p_iclr) else $error("clear register reads nonzero");
	a_istat: assert property (p_istat) else $error("status spare bits set");
	a_mode: assert property (p_mode) else $error("mode readback wrong");
	a_xcfg: assert property (p_xcfg) else $error("polarity readback wrong");
	a_ien: assert property (p_ien) else $error("enable readback wrong");
	a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
endmodule : dtc_top_asserts
bind dtc_top dtc_top_asserts u_dtc_top_asserts (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.count_input_a_i(count_input_a_i), .count_input_b_i(count_input_b_i),
	.gate_input_a_i(gate_input_a_i), .gate_input_b_i(gate_input_b_i), .irq_o(irq_o));

/* File: testbench/dtc_top_tb.sv */
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_top_tb;
	import dtc_pkg::*;
	logic sys_clk = 1'b0; // 200 MHz
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic [1:0] cnt_pin;
	logic [1:0] gate_pin;
	logic [1:0] fall_req = 2'h0; // One-cycle fall commands
	logic [1:0] gate_req = 2'h0; // Gate pin levels
	logic [7:0] v0;
	logic [7:0] v1;
	int n_mismatch = 0;
	int num_checks = 0;
	dtc_top u_dtc_top (.sys_clk_i(sys_clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .count_input_a_i(cnt_pin[0]),
		.count_input_b_i(cnt_pin[1]), .gate_input_a_i(gate_pin[0]),
		.gate_input_b_i(gate_pin[1]), .irq_o(irq));
	dtc_pin_model u_dtc_pin_model (.sys_clk_i(sys_clk), .rstn_i(rstn), .fall_i(fall_req),
		.gate_i(gate_req),
		.cnt_o(cnt_pin), .gate_o(gate_pin));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ---------------------------------------------------------------
	// Bus and compare helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wt
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		chk(nm, e, d);
	endtask : rd_chk
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		for (int a = 0; a < 12; a++) rd_chk("reset reg", a[7:0], 8'h00);
	endtask : t_reset
	task automatic t_wrap16;
		wr_reg(`DTC_ADDR_MODE, 8'h01);
		wr_reg(`DTC_ADDR_SCALE, 8'h04);
		wr_reg(`DTC_ADDR_A_LO, 8'hf0);
		wr_reg(`DTC_ADDR_A_HI, 8'hff);
		wr_reg(`DTC_ADDR_IEN, 8'h01);
		wr_reg(`DTC_ADDR_CTRL, 8'h10);
		wt(30);
		chk("irq", 8'h01, {7'h0, irq});
		rd_chk("ctrl", `DTC_ADDR_CTRL, 8'h30);
		rd_chk("istat", `DTC_ADDR_ISTAT, 8'h01);
		wr_reg(`DTC_ADDR_CTRL, 8'h00);
		rd_chk("a_hi", `DTC_ADDR_A_HI, 8'h00);
		rd_reg(`DTC_ADDR_A_LO, v0);
		wt(20);
		rd_chk("a_lo hold", `DTC_ADDR_A_LO, v0);
		wr_reg(`DTC_ADDR_IEN, 8'h00);
		wt(3);
		chk("irq off", 8'h00, {7'h0, irq});
		wr_reg(`DTC_ADDR_IEN, 8'h01);
		wt(3);
		chk("irq on", 8'h01, {7'h0, irq});
		wr_reg(`DTC_ADDR_ICLR, 8'h01);
		wt(3);
		chk("irq clr", 8'h00, {7'h0, irq});
		wr_reg(`DTC_ADDR_CTRL, 8'h10);
		wt(5);
		wr_reg(`DTC_ADDR_CTRL, 8'h00);
		rd_reg(`DTC_ADDR_A_LO, v1);
		chk("resume", 8'h01, {7'h0, v1 > v0 && v1 < v0 + 8'h10});
	endtask : t_wrap16
	task automatic t_wrap13;
		wr_reg(`DTC_ADDR_SCALE, 8'h08);
		wr_reg(`DTC_ADDR_B_LO, 8'h1e);
		wr_reg(`DTC_ADDR_B_HI, 8'hff);
		wr_reg(`DTC_ADDR_IEN, 8'h02);
		wr_reg(`DTC_ADDR_CTRL, 8'h40);
		wt(12);
		wr_reg(`DTC_ADDR_CTRL, 8'h00);
		rd_chk("b_hi", `DTC_ADDR_B_HI, 8'h00);
		rd_chk("istat b", `DTC_ADDR_ISTAT, 8'h02);
		chk("irq b", 8'h01, {7'h0, irq});
		rd_chk("a_lo kept", `DTC_ADDR_A_LO, v1);
		wr_reg(`DTC_ADDR_ICLR, 8'h02);
	endtask : t_wrap13
	task automatic t_gate;
		wr_reg(`DTC_ADDR_MODE, 8'h09);
		wr_reg(`DTC_ADDR_SCALE, 8'h04);
		wr_reg(`DTC_ADDR_XCFG, 8'h08);
		wr_reg(`DTC_ADDR_CTRL, 8'h10);
		rd_reg(`DTC_ADDR_A_LO, v0);
		wt(10);
		rd_chk("gated", `DTC_ADDR_A_LO, v0);
		gate_req <= 2'h1;
		wt(8);
		rd_reg(`DTC_ADDR_A_LO, v0);
		wt(10);
		rd_reg(`DTC_ADDR_A_LO, v1);
		chk("gate open", 8'h01, {7'h0, v1 != v0});
		wr_reg(`DTC_ADDR_XCFG, 8'h00);
		wt(8);
		rd_reg(`DTC_ADDR_A_LO, v0);
		wt(10);
		rd_chk("pol low", `DTC_ADDR_A_LO, v0);
		wr_reg(`DTC_ADDR_CTRL, 8'h00);
	endtask : t_gate
	// Timer b gate with its own polarity; mode 10 on timer a holds
	task automatic t_gate_b;
		wr_reg(`DTC_ADDR_MODE, 8'h92);
		wr_reg(`DTC_ADDR_SCALE, 8'h0c);
		wr_reg(`DTC_ADDR_XCFG, 8'h80);
		wr_reg(`DTC_ADDR_CTRL, 8'h50);
		rd_reg(`DTC_ADDR_A_LO, v0);
		rd_reg(`DTC_ADDR_B_LO, v1);
		wt(10);
		rd_chk("mode 10 hold", `DTC_ADDR_A_LO, v0);
		rd_chk("b gated", `DTC_ADDR_B_LO, v1);
		gate_req <= 2'h2;
		wt(8);
		rd_reg(`DTC_ADDR_B_LO, v0);
		wt(10);
		rd_reg(`DTC_ADDR_B_LO, v1);
		chk("b gate open", 8'h01, {7'h0, v1 != v0});
		wr_reg(`DTC_ADDR_CTRL, 8'h00);
	endtask : t_gate_b
	task automatic t_pin;
		wr_reg(`DTC_ADDR_MODE, 8'h51);
		wr_reg(`DTC_ADDR_B_LO, 8'h00);
		wr_reg(`DTC_ADDR_B_HI, 8'h00);
		wr_reg(`DTC_ADDR_CTRL, 8'h40);
		repeat (3) begin
			fall_req <= 2'h2;
			@(posedge sys_clk);
			fall_req <= 2'h0;
			wt(20);
		end
		rd_chk("pin count", `DTC_ADDR_B_LO, 8'h03);
		wr_reg(`DTC_ADDR_CTRL, 8'h00);
	endtask : t_pin
	// Two reads 162 cycles apart give 162 over the divisor
	task automatic t_scale;
		int e;
		wr_reg(`DTC_ADDR_MODE, 8'h01);
		for (int k = 0; k < 4; k++) begin
			e = 162 / (2 << k);
			wr_reg(`DTC_ADDR_SCALE, k[7:0]);
			wr_reg(`DTC_ADDR_CTRL, 8'h10);
			rd_reg(`DTC_ADDR_A_LO, v0);
			wt(160);
			rd_reg(`DTC_ADDR_A_LO, v1);
			wr_reg(`DTC_ADDR_CTRL, 8'h00);
			v1 = v1 - v0;
			chk("prescale", 8'h01, {7'h0, v1 + 8'h01 >= e[7:0] && v1 <= e[7:0] + 8'h01});
		end
	endtask : t_scale
	task automatic wrap_up;
		$display("Compares %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_wrap16();
		t_wrap13();
		t_gate();
		t_gate_b();
		t_pin();
		t_scale();
		wrap_up();
	end
	// Watchdog well past the expected thousand or so cycles
	initial begin
		wt(8000);
		n_mismatch++;
		wrap_up();
	end
endmodule : dtc_top_tb
